// ### rtl/pfpc_defines.vh
// constants for the protection switch and pin control block
`ifndef PFPC_DEFINES_VH
`define PFPC_DEFINES_VH
// clock rate and shutdown hold time
`define PFPC_CLK_HZ 200000000
`define PFPC_HOLD_MS 1000
`define PFPC_HOLD_CYCLES 200000000
// user ldo voltage codes
`define PFPC_LDO_1V8 3'h0
`define PFPC_LDO_2V5 3'h1
`define PFPC_LDO_3V0 3'h2
`define PFPC_LDO_3V3 3'h3
`define PFPC_LDO_5V0 3'h4
`define PFPC_LDO_DEFAULT 3'h3
// converter input selector codes
`define PFPC_MUX_CELL 4'h0
`define PFPC_MUX_TEMP 4'h5
`define PFPC_MUX_THERM_A 4'h6
`define PFPC_MUX_THERM_B 4'h7
`define PFPC_MUX_CORE 4'h8
`define PFPC_MUX_GND 4'h9
`define PFPC_MUX_TOP 4'ha
`define PFPC_MUX_PACK 4'hb
`define PFPC_MUX_LOAD 4'hc
`define PFPC_MUX_GPIN 4'hd
// pin function codes
`define PFPC_FN_ALARM 2'h0
`define PFPC_FN_LINK 2'h1
`define PFPC_FN_INPUT 2'h1
`define PFPC_FN_BOTH 2'h2
`define PFPC_FN_GPO 2'h3
`endif

// ### rtl/pfpc_sync.v
// two flip-flop synchroniser for one pin level
`timescale 1ns/10ps
`default_nettype none
module pfpc_sync (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// level in and out
	input wire din,
	output reg dout
);
	reg stage;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage <= din;
			dout <= stage;
		end
	end
endmodule // pfpc_sync
`default_nettype wire

// ### rtl/pfpc_top.v
// protection switch gating, load detect recovery and pin controls
`timescale 1ns/10ps
`default_nettype none
`include "pfpc_defines.vh"
//
// Function
// [RULE_01] low cell routes charging via precharge
// [RULE_02] predischarge first, then discharge switch
// [RULE_03] optional load-removal recovery of latched faults
// [RULE_04] pulse load current, clear above 4V
// [RULE_05] below 4V keeps fault latched
// [RULE_06] on time, off time, repeat until timeout
// [RULE_07] converter input selector choices
// [RULE_08] user ldo five voltage settings
// [RULE_09] default ldo and preregulator on, 3.3V
// [RULE_10] load otp settings at power-up
// [RULE_11] host link i2c default or single-wire
// [RULE_12] manual mode flags only, host disables
// [RULE_13] output high level from chosen ldo
// [RULE_14] pin function selection options
// [RULE_15] general outputs by command, weak pulls
// [RULE_16] reset pin high resets most logic
// [RULE_17] switch and fuse state survive pin reset
// [RULE_18] reset pin high 1s enters shutdown
// [RULE_19] off input disables switch directly
// [RULE_20] release re-enables only without blockers
// [RULE_21] off functions disable their switch pairs
// [RULE_22] both-off input disables all four switches
// [RULE_23] present fault blocks re-enable
// [RULE_24] early release clears shutdown timer
module pfpc_top #(
	parameter HOLD_CYCLES = `PFPC_HOLD_CYCLES
) (
	// clock and power-up reset
	input wire clk,
	input wire reset_n,
	// one-time-programmable settings, valid at power-up
	input wire otp_valid,
	input wire otp_ldo_en,
	input wire [2:0] otp_ldo_sel,
	input wire otp_prereg_en,
	input wire otp_link_single,
	// pins from outside
	input wire reset_shut_pin,
	input wire charge_off_input,
	input wire discharge_off_input,
	input wire load_sense_high,
	// measurements and faults from core logic
	input wire low_cell,
	input wire latched_dsg_fault,
	input wire fault_present,
	input wire alert_flag,
	// configuration
	input wire manual_mode,
	input wire predischarge_en,
	input wire load_detect_en,
	input wire [15:0] ld_on_cycles,
	input wire [15:0] ld_off_cycles,
	input wire [7:0] ld_max_periods,
	input wire [1:0] alarm_fn,
	input wire [1:0] charge_off_fn,
	input wire [1:0] discharge_off_fn,
	input wire [2:0] gpo_level,
	input wire [2:0] gpo_pull_en,
	input wire [2:0] gpo_pull_up,
	input wire gpo_from_core,
	input wire [3:0] mux_req,
	// host commands
	input wire cmd_chg_on,
	input wire cmd_dsg_on,
	input wire fault_autodisable,
	input wire alarm_irq,
	// switch drives
	output reg charge_switch,
	output reg precharge_switch,
	output reg discharge_switch,
	output reg predischarge_switch,
	// load detect
	output reg ld_source_on,
	output reg ld_recovered,
	output reg fault_flag,
	// power control
	output reg user_ldo_en,
	output reg [2:0] user_ldo_sel,
	output reg prereg_en,
	output reg core_ldo_en,
	output reg osc_en,
	output reg link_single,
	output reg logic_reset,
	// pins as outputs
	output reg [2:0] pin_out,
	output reg [2:0] pin_oe,
	output reg [2:0] pin_pull_dn,
	output reg [2:0] pin_pull_up,
	output reg pin_src_core,
	output reg [3:0] mux_sel
);
	////////////////////////////////////////////////////////////////
	wire rst_pin;
	wire cof_pin;
	wire dof_pin;
	wire lds_pin;
	pfpc_sync u_s0 (.clk(clk), .reset_n(reset_n), .din(reset_shut_pin), .dout(rst_pin));
	pfpc_sync u_s1 (.clk(clk), .reset_n(reset_n), .din(charge_off_input), .dout(cof_pin));
	pfpc_sync u_s2 (.clk(clk), .reset_n(reset_n), .din(discharge_off_input), .dout(dof_pin));
	pfpc_sync u_s3 (.clk(clk), .reset_n(reset_n), .din(load_sense_high), .dout(lds_pin));
	////////////////////////////////////////////////////////////////
	// shutdown hold timer
	reg [27:0] hold_cnt;
	reg shutdown;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_cnt <= 28'h000_0000;
			shutdown <= 1'b0;
			logic_reset <= 1'b0;
		end else begin
			logic_reset <= rst_pin; // [RULE_16]
			if (!rst_pin) begin
				hold_cnt <= 28'h000_0000; // [RULE_24]
			end else if (hold_cnt >= HOLD_CYCLES[27:0] - 28'h000_0001) begin
				shutdown <= 1'b1; // [RULE_18]
			end else begin
				hold_cnt <= hold_cnt + 28'h000_0001;
			end
		end
	end
	wire soft_rst = rst_pin;
	////////////////////////////////////////////////////////////////
	// power-up settings load
	reg loaded;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			loaded <= 1'b0;
			user_ldo_en <= 1'b1; // [RULE_09]
			user_ldo_sel <= `PFPC_LDO_DEFAULT;
			prereg_en <= 1'b1;
			core_ldo_en <= 1'b1;
			osc_en <= 1'b1;
			link_single <= 1'b0; // [RULE_11]
		end else if (shutdown) begin
			user_ldo_en <= 1'b0; // [RULE_18]
			prereg_en <= 1'b0;
			core_ldo_en <= 1'b0;
			osc_en <= 1'b0;
		end else if (!loaded && otp_valid) begin
			loaded <= 1'b1; // [RULE_10]
			user_ldo_en <= otp_ldo_en;
			prereg_en <= otp_prereg_en;
			link_single <= otp_link_single; // [RULE_11]
			if (otp_ldo_sel <= `PFPC_LDO_5V0) begin
				user_ldo_sel <= otp_ldo_sel; // [RULE_08]
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// pin functions and switch-off blockers
	wire both_off = (discharge_off_fn == `PFPC_FN_BOTH) && dof_pin; // [RULE_22]
	wire chg_block_pin = ((charge_off_fn == `PFPC_FN_INPUT) && cof_pin) || both_off; // [RULE_21]
	wire dsg_block_pin = ((discharge_off_fn == `PFPC_FN_INPUT) && dof_pin) || both_off; // [RULE_21]
	wire fault_block = fault_present && !manual_mode && fault_autodisable; // [RULE_12]
	wire ld_latched;
	wire chg_allow = cmd_chg_on && !chg_block_pin && !fault_block && !shutdown; // [RULE_19] [RULE_20] [RULE_23]
	wire dsg_allow = cmd_dsg_on && !dsg_block_pin && !fault_block && !ld_latched && !shutdown; // [RULE_20] [RULE_23]
	////////////////////////////////////////////////////////////////
	// switch state, outside the pin-driven soft reset
	localparam PD_OFF = 2'h0;
	localparam PD_PRE = 2'h1;
	localparam PD_ON = 2'h2;
	reg [1:0] pd_state;
	reg [15:0] pd_cnt;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			charge_switch <= 1'b0;
			precharge_switch <= 1'b0;
			discharge_switch <= 1'b0;
			predischarge_switch <= 1'b0;
			pd_state <= PD_OFF;
			pd_cnt <= 16'h0000;
		end else begin
			// not cleared by soft_rst, state holds through it
			charge_switch <= chg_allow && !low_cell; // [RULE_17] [RULE_01]
			precharge_switch <= chg_allow && low_cell; // [RULE_01]
			case (pd_state)
				PD_OFF: begin
					discharge_switch <= 1'b0;
					predischarge_switch <= 1'b0;
					pd_cnt <= 16'h0000;
					if (dsg_allow) begin
						if (predischarge_en) begin
							pd_state <= PD_PRE;
							predischarge_switch <= 1'b1; // [RULE_02]
						end else begin
							pd_state <= PD_ON;
							discharge_switch <= 1'b1;
						end
					end
				end
				PD_PRE: begin
					if (!dsg_allow) begin
						pd_state <= PD_OFF;
						predischarge_switch <= 1'b0;
					end else if (pd_cnt >= ld_on_cycles) begin
						pd_state <= PD_ON;
						discharge_switch <= 1'b1; // [RULE_02]
						predischarge_switch <= 1'b0;
					end else begin
						pd_cnt <= pd_cnt + 16'h0001;
					end
				end
				PD_ON: begin
					if (!dsg_allow) begin
						pd_state <= PD_OFF;
						discharge_switch <= 1'b0; // [RULE_19]
					end
				end
				default: begin
					pd_state <= PD_OFF;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// load detect recovery
	localparam LD_IDLE = 2'h0;
	localparam LD_ON = 2'h1;
	localparam LD_OFF = 2'h2;
	localparam LD_DONE = 2'h3;
	reg [1:0] ld_state;
	reg [15:0] ld_cnt;
	reg [7:0] ld_per;
	reg fault_latch;
	assign ld_latched = fault_latch;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ld_state <= LD_IDLE;
			ld_cnt <= 16'h0000;
			ld_per <= 8'h00;
			fault_latch <= 1'b0;
			ld_source_on <= 1'b0;
			ld_recovered <= 1'b0;
		end else begin
			ld_recovered <= 1'b0;
			case (ld_state)
				LD_IDLE: begin
					ld_cnt <= 16'h0000;
					ld_per <= 8'h00;
					if (fault_latch && !discharge_switch && load_detect_en) begin // [RULE_03]
						ld_state <= LD_ON;
						ld_source_on <= 1'b1; // [RULE_04]
						ld_cnt <= 16'h0001;
					end
				end
				LD_ON: begin
					if (lds_pin) begin
						fault_latch <= 1'b0; // [RULE_04]
						ld_recovered <= 1'b1;
						ld_source_on <= 1'b0;
						ld_state <= LD_IDLE;
					end else if (ld_cnt >= ld_on_cycles) begin
						ld_source_on <= 1'b0; // [RULE_05]
						ld_cnt <= 16'h0001;
						ld_per <= ld_per + 8'h01;
						ld_state <= LD_OFF; // [RULE_06]
					end else begin
						ld_cnt <= ld_cnt + 16'h0001;
					end
				end
				LD_OFF: begin
					if (ld_per >= ld_max_periods) begin
						ld_state <= LD_DONE; // [RULE_06]
					end else if (ld_cnt >= ld_off_cycles) begin
						ld_cnt <= 16'h0001;
						ld_source_on <= 1'b1;
						ld_state <= LD_ON;
					end else begin
						ld_cnt <= ld_cnt + 16'h0001;
					end
				end
				LD_DONE: begin
					if (!fault_latch || !load_detect_en) begin
						ld_state <= LD_IDLE;
					end
				end
				default: begin
					ld_state <= LD_IDLE;
				end
			endcase
			// a new fault wins over a recovery in the same cycle
			if (latched_dsg_fault) begin
				fault_latch <= 1'b1;
			end
			if (soft_rst && ld_state != LD_IDLE) begin
				ld_state <= LD_IDLE; // [RULE_16]
				ld_source_on <= 1'b0;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// flags, general outputs and converter selector
	reg [2:0] is_gpo;
	always @* begin
		is_gpo[0] = (alarm_fn == `PFPC_FN_GPO);
		is_gpo[1] = (charge_off_fn == `PFPC_FN_GPO);
		is_gpo[2] = (discharge_off_fn == `PFPC_FN_GPO);
	end
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fault_flag <= 1'b0;
			pin_out <= 3'h0;
			pin_oe <= 3'h0;
			pin_pull_dn <= 3'h0;
			pin_pull_up <= 3'h0;
			pin_src_core <= 1'b0;
			mux_sel <= `PFPC_MUX_CELL;
		end else if (soft_rst || shutdown) begin
			fault_flag <= 1'b0;
			pin_oe <= 3'h0;
			pin_out <= 3'h0;
		end else begin
			fault_flag <= alert_flag || fault_present; // [RULE_12]
			pin_src_core <= gpo_from_core; // [RULE_13]
			pin_out <= gpo_level & is_gpo; // [RULE_15]
			pin_oe <= is_gpo;
			pin_pull_dn <= is_gpo & gpo_pull_en & ~gpo_pull_up; // [RULE_15]
			pin_pull_up <= is_gpo & gpo_pull_en & gpo_pull_up;
			if (alarm_fn == `PFPC_FN_ALARM) begin
				pin_out[0] <= alarm_irq; // [RULE_14]
				pin_oe[0] <= 1'b1;
			end
			if (mux_req <= `PFPC_MUX_GPIN) begin
				mux_sel <= mux_req; // [RULE_07]
			end
		end
	end
endmodule // pfpc_top
`default_nettype wire

// ### verification/pfpc_top_properties.sv
// assertions on the switch gating, load detect and reset pin ports
`timescale 1ns/10ps
`default_nettype none
module pfpc_checker #(parameter HOLD_CYCLES = 100) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pins and levels
	input wire logic reset_shut_pin, charge_off_input, discharge_off_input, load_sense_high,
	input wire logic low_cell, fault_present, manual_mode, fault_autodisable, predischarge_en,
	input wire logic [1:0] charge_off_fn,
	input wire logic [1:0] discharge_off_fn,
	// outputs
	input wire logic charge_switch, precharge_switch, discharge_switch, predischarge_switch,
	input wire logic ld_recovered, logic_reset, osc_en, core_ldo_en, user_ldo_en, prereg_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	//////////////////////////////////////////////////////////////////////////////
	reg [31:0] hold_cnt;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			hold_cnt <= 32'h0000_0000;
		else if (reset_shut_pin)
			hold_cnt <= hold_cnt + 32'h0000_0001;
		else
			hold_cnt <= 32'h0000_0000;
	end
	sequence s_both_held;
		(discharge_off_fn == 2'h2 && discharge_off_input)[*4];
	endsequence
	sequence s_dsg_held;
		(discharge_off_fn != 2'h0 && discharge_off_fn != 2'h3 && discharge_off_input)[*4];
	endsequence
	//////////////////////////////////////////////////////////////////////////////
	a_both_off_all: assert property (s_both_held |->
		!(charge_switch | precharge_switch | discharge_switch | predischarge_switch))
		else $error("both-off left a switch on");
	a_chg_off_pair: assert property ((charge_off_fn == 2'h1 && charge_off_input)[*4]
		|-> !charge_switch && !precharge_switch) else $error("charge pair still on");
	a_dsg_off_pair: assert property (s_dsg_held |-> !discharge_switch && !predischarge_switch)
		else $error("discharge pair still on");
	a_low_cell_route: assert property ($past(low_cell) && low_cell |-> !charge_switch)
		else $error("main charge switch on with low cell");
	a_predischarge_switch_first: assert property ($rose(discharge_switch) && $past(predischarge_en)
		|-> $past(predischarge_switch) && !predischarge_switch) else $error("predischarge order");
	a_ld_recover: assert property (ld_recovered |-> $past(load_sense_high, 2)
		|| $past(load_sense_high, 3) || $past(load_sense_high, 4)) else $error("recovery without load sense");
	a_fault_block: assert property ((fault_present && fault_autodisable && !manual_mode)[*3]
		|-> !charge_switch && !discharge_switch) else $error("switch on with fault");
	a_soft_reset: assert property (reset_shut_pin[*4] |-> logic_reset)
		else $error("reset pin not applied");
	a_shut_power: assert property (hold_cnt > HOLD_CYCLES + 6 |-> !osc_en && !core_ldo_en
		&& !user_ldo_en && !prereg_en && !charge_switch && !discharge_switch) else $error("no shutdown");
endmodule // pfpc_checker
`default_nettype wire

// ### verification/pfpc_host_model.sv
// host side model driving the control pins and the load on the sense pin
`timescale 1ns/10ps
`default_nettype none
module pfpc_host_model (
	input wire logic clk, ld_source_on, want_chg_off, want_dsg_off, want_shut, load_present,
	output logic charge_off_input, discharge_off_input, reset_shut_pin, load_sense_high
);
	always @(posedge clk) begin
		charge_off_input <= want_chg_off;
		discharge_off_input <= want_dsg_off;
		reset_shut_pin <= want_shut;
		// a present load pulls the pin below 4V even while current is sourced
		load_sense_high <= ld_source_on && !load_present;
	end
endmodule // pfpc_host_model
`default_nettype wire

// ### verification/tb_protection_fet_pin_control.sv
// testbench for the protection switch and pin control block
`timescale 1ns/10ps
`default_nettype none
`include "pfpc_defines.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_protection_fet_pin_control;
	logic clk = 1'b0, reset_n = 1'b0, otp_valid = 1'b0, otp_ldo_en = 1'b1, otp_prereg_en = 1'b1;
	logic otp_link_single = 1'b1, low_cell = 1'b0, latched_dsg_fault = 1'b0, fault_present = 1'b0;
	logic alert_flag = 1'b0, manual_mode = 1'b0, predischarge_en = 1'b0, load_detect_en = 1'b0;
	logic fault_autodisable = 1'b1, alarm_irq = 1'b0, cmd_chg_on = 1'b0, cmd_dsg_on = 1'b0;
	logic gpo_from_core = 1'b0, want_chg_off = 1'b0, want_dsg_off = 1'b0, want_shut = 1'b0;
	logic load_present = 1'b1;
	logic [2:0] otp_ldo_sel = 3'h4, gpo_level = 3'h0, gpo_pull_en = 3'h0, gpo_pull_up = 3'h0;
	logic [1:0] alarm_fn = 2'h0, charge_off_fn = 2'h1, discharge_off_fn = 2'h1;
	logic [15:0] ld_on_cycles = 16'h000a, ld_off_cycles = 16'h000a;
	logic [7:0] ld_max_periods = 8'h08;
	logic [3:0] mux_req = 4'h0;
	wire reset_shut_pin, charge_off_input, discharge_off_input, load_sense_high, ld_source_on;
	wire charge_switch, precharge_switch, discharge_switch, predischarge_switch, ld_recovered;
	wire fault_flag, user_ldo_en, prereg_en, core_ldo_en, osc_en, link_single, logic_reset;
	wire pin_src_core;
	wire [2:0] user_ldo_sel, pin_out, pin_oe, pin_pull_dn, pin_pull_up;
	wire [3:0] mux_sel;
	int fail_count = 0, compares = 0, i;
	always #2.5 clk = ~clk;
	pfpc_top #(.HOLD_CYCLES(100)) DUT (.*);
	pfpc_host_model host (.*);
	//////////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task bound(input int n);
		if (i >= n) begin
			fail_count++;
			$display("MISMATCH wait exp done got timeout");
			stop_test();
		end
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task t_power;
		`CHK("ldo sel", `PFPC_LDO_DEFAULT, user_ldo_sel)
		`CHK("ldo on", 2'h3, {user_ldo_en, prereg_en})
		`CHK("link", 1'b0, link_single)
		reset_n = 1'b1;
		otp_valid = 1'b1;
		cyc(3);
		`CHK("otp sel", `PFPC_LDO_5V0, user_ldo_sel)
		`CHK("otp link", 1'b1, link_single)
		otp_ldo_sel = `PFPC_LDO_2V5;
		cyc(3);
		`CHK("otp once", `PFPC_LDO_5V0, user_ldo_sel)
		$display("power test done");
	endtask
	task t_charge;
		{cmd_chg_on, low_cell} = 2'h3;
		cyc(2);
		`CHK("precharge_switch", 2'h1, {charge_switch, precharge_switch})
		low_cell = 1'b0;
		cyc(2);
		`CHK("chg", 2'h2, {charge_switch, precharge_switch})
		want_chg_off = 1'b1;
		cyc(5);
		`CHK("chg pin", 2'h0, {charge_switch, precharge_switch})
		{cmd_chg_on, want_chg_off} = 2'h0;
		cyc(5);
		`CHK("chg held", 1'b0, charge_switch)
		{cmd_chg_on, fault_present} = 2'h3;
		cyc(4);
		`CHK("fault", 1'b0, charge_switch)
		manual_mode = 1'b1;
		cyc(3);
		`CHK("manual", 1'b1, charge_switch)
		`CHK("flag", 1'b1, fault_flag)
		{manual_mode, fault_present} = 2'h0;
		$display("charge test done");
	endtask
	task t_dsg;
		{predischarge_en, cmd_dsg_on} = 2'h3;
		cyc(3);
		`CHK("predischarge_switch first", 2'h1, {discharge_switch, predischarge_switch})
		for (i = 0; i < 40 && discharge_switch !== 1'b1; i++) cyc(1);
		bound(40);
		`CHK("predischarge_switch swap", 1'b0, predischarge_switch)
		`CHK("dwell", 1'b1, i >= 6 && i <= 10)
		{discharge_off_fn, want_dsg_off} = 3'h5;
		cyc(5);
		`CHK("both off", 4'h0, {charge_switch, precharge_switch, discharge_switch, predischarge_switch})
		{discharge_off_fn, want_dsg_off} = 3'h2;
		for (i = 0; i < 40 && discharge_switch !== 1'b1; i++) cyc(1);
		bound(40);
		want_dsg_off = 1'b1;
		cyc(5);
		`CHK("dsg pair", 3'h4, {charge_switch, discharge_switch, predischarge_switch})
		{want_dsg_off, predischarge_en} = 2'h0;
		cyc(5);
		`CHK("dsg direct", 2'h2, {discharge_switch, predischarge_switch})
		$display("discharge test done");
	endtask
	task t_load;
		{load_detect_en, latched_dsg_fault} = 2'h3;
		cyc(1);
		latched_dsg_fault = 1'b0;
		cyc(20);
		`CHK("latched", 1'b0, discharge_switch)
		for (i = 0; i < 40 && ld_source_on !== 1'b1; i++) cyc(1);
		bound(40);
		for (i = 0; i < 40 && ld_source_on === 1'b1; i++) cyc(1);
		`CHK("on time", ld_on_cycles, i[15:0])
		load_present = 1'b0;
		for (i = 0; i < 40 && ld_recovered !== 1'b1; i++) cyc(1);
		bound(40);
		`CHK("recovered", 1'b1, ld_recovered)
		$display("load detect test done");
	endtask
	task t_pins;
		alarm_irq = 1'b1;
		cyc(2);
		`CHK("alarm", 2'h3, {pin_oe[0], pin_out[0]})
		{alarm_fn, charge_off_fn, discharge_off_fn} = 6'h3f;
		{gpo_level, gpo_pull_en, gpo_pull_up, gpo_from_core} = 10'h2f5;
		mux_req = `PFPC_MUX_LOAD;
		cyc(3);
		`CHK("gpo", 3'h5, pin_out)
		`CHK("oe", 3'h7, pin_oe)
		`CHK("pulls", 6'h15, {pin_pull_up, pin_pull_dn})
		`CHK("src", 1'b1, pin_src_core)
		`CHK("mux", `PFPC_MUX_LOAD, mux_sel)
		mux_req = 4'hf;
		cyc(3);
		`CHK("mux hold", `PFPC_MUX_LOAD, mux_sel)
		$display("pin test done");
	endtask
	task t_shut;
		want_shut = 1'b1;
		cyc(50);
		`CHK("soft reset", 1'b1, logic_reset)
		`CHK("kept", 1'b1, charge_switch)
		want_shut = 1'b0;
		cyc(5);
		`CHK("no shut", 2'h3, {osc_en, user_ldo_en})
		want_shut = 1'b1;
		cyc(90);
		`CHK("timer cleared", 1'b1, osc_en)
		cyc(25);
		`CHK("shut", 5'h00, {osc_en, core_ldo_en, prereg_en, user_ldo_en, charge_switch})
		$display("shutdown test done");
	endtask
	initial begin
		cyc(8);
		t_power;
		t_charge;
		t_dsg;
		t_load;
		t_pins;
		t_shut;
		stop_test;
	end
endmodule // tb_protection_fet_pin_control
bind pfpc_top pfpc_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);
`default_nettype wire
